//--- rtl/fib_consts.svh
// Register offsets, field positions, reset values and counts for the formatter port block
`ifndef FIB_CONSTS_SVH
`define FIB_CONSTS_SVH

// Register indexes on the microcontroller bus
`define FIB_ADDR_CAPTURE 8'h4d
`define FIB_ADDR_PORT 8'h70
`define FIB_ADDR_FLAGS 8'h7d
`define FIB_ADDR_ENABLES 8'h7e
`define FIB_ADDR_STACK 8'h7f
`define FIB_ADDR_TIMING 8'h7f

// Reset values
`define FIB_FLAGS_RST 7'h00
`define FIB_ENABLES_RST 7'h00
`define FIB_TIMING_RST 8'h80
`define FIB_CAPTURE_RST 8'h00

// Field positions in the event flag register
`define FIB_BIT_HOST_SUMMARY 7
`define FIB_NUM_EVENTS 7

// Stack geometry
`define FIB_STACK_DEPTH 8
`define FIB_STACK_PTR_W 3

// Buffer address width
`define FIB_BUF_ADDR_W 16

`endif

//--- rtl/fib_pkg.sv
// Types shared by the formatter interrupt and buffer port block
package fib_pkg;

   // Event sources, one bit per status flag 0..6
   typedef struct packed {
      logic seq_output;   // Sequencer general output level
      logic xfer_status;  // Data-transfer-in-progress level
      logic ecc_error;    // Nonzero syndrome after last ECC bit
      logic seq_stopped;  // Sequencer stopped level
      logic gen_input;    // General input pin
      logic mark_sector;  // Shared mark/sector pin
      logic index;        // Drive index pulse
   } fib_events_t;

   // Layout of the write-only timing and sync register
   typedef struct packed {
      logic [1:0] rate;   // Buffer access rate code
      logic clk_dis;      // Test-only internal clock stop
      logic wr_oe_dis;    // Output enable held off on writes
      logic rsvd;         // Reserved
      logic [2:0] sync_cmp; // Sync compare width code
   } fib_timing_t;

   // Buffer port access sequencer, one-hot
   typedef enum logic [2:0] {
      FIB_IDLE = 3'b001,
      FIB_ACC = 3'b010,
      FIB_DONE = 3'b100
   } fib_state_t;

endpackage

//--- rtl/fib_read_stack.sv
// Eight-entry circular capture stack with non-destructive backward reads
`timescale 1ns/1ns
`include "fib_consts.svh"

module fib_read_stack (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic push_i,
   input wire logic [7:0] push_data_i,
   input wire logic read_i,
   output logic [7:0] read_data_o
);

   // Storage and pointers
   logic [7:0] mem [0:`FIB_STACK_DEPTH-1];
   logic [`FIB_STACK_PTR_W-1:0] wr_ptr; // Next slot to fill
   logic [`FIB_STACK_PTR_W-1:0] rd_ptr; // Slot a read returns
   logic [`FIB_STACK_PTR_W-1:0] next_wr_ptr;
   logic [`FIB_STACK_PTR_W-1:0] newest_ptr;

   // Pointer arithmetic wraps naturally in three bits
   assign next_wr_ptr = wr_ptr + 3'h1;
   assign newest_ptr = wr_ptr;
   assign read_data_o = mem[rd_ptr];

   // Array writes: oldest entry overwritten after eight pushes
   always_ff @(posedge sys_clk_i) begin
      if (push_i) begin
         mem[wr_ptr] <= push_data_i;
      end
   end

   // Pointers: push makes newest readable, read steps back one
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ptr <= 3'h0;
         rd_ptr <= 3'h0;
      end else if (push_i) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= newest_ptr;
      end else if (read_i) begin
         rd_ptr <= rd_ptr - 3'h1;
      end
   end

endmodule

//--- rtl/fib_irq_buf_port.sv
// Formatter event flags, enables, read stack, timing control and buffer access port
`timescale 1ns/1ns
`include "fib_consts.svh"

module fib_irq_buf_port (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Microcontroller register port
   input wire logic [7:0] mcu_addr_i,
   input wire logic [7:0] mcu_wdata_i,
   input wire logic mcu_rd_i,
   input wire logic mcu_wr_i,
   output logic [7:0] mcu_rdata_o,
   output logic mcu_ready_o,
   // Event sources and context
   input wire fib_pkg::fib_events_t events_i,
   input wire logic hard_sector_i,
   input wire logic [4:0] host_irq_bits_i,
   input wire logic stack_push_i,
   input wire logic [7:0] stack_data_i,
   input wire logic formatter_reset_i,
   input wire logic auto_inc_i,
   input wire logic moe_suppress_i,
   // Buffer pointers kept by the buffer manager
   input wire logic [`FIB_BUF_ADDR_W-1:0] buffer_read_pointer_i,
   input wire logic [`FIB_BUF_ADDR_W-1:0] buffer_write_pointer_i,
   output logic read_ptr_inc_o,
   output logic write_ptr_inc_o,
   // Formatter and host buffer traffic
   input wire logic ext_buf_oe_i,
   input wire logic ext_buf_write_i,
   // Buffer memory pins
   input wire logic [7:0] buf_data_i,
   output logic [7:0] buf_data_o,
   output logic buf_data_oe_n_o,
   output logic [`FIB_BUF_ADDR_W-1:0] buf_addr_o,
   output logic buffer_out_enable_n_o,
   output logic buffer_write_en_n_o,
   // Status and control outputs
   output logic fmt_int_n_o,
   output logic revolution_mark_flag_o,
   output logic sector_pulse_flag_o,
   output logic gate_inhibit_o,
   output logic [7:0] sync_mask_o,
   output logic [1:0] access_rate_o,
   output logic clk_disable_o
);

   // Cycles per buffer access for each rate code
   function automatic logic [2:0] rate_cycles(input logic [1:0] code);
      case (code)
         2'h0: rate_cycles = 3'h4;
         2'h1: rate_cycles = 3'h2;
         2'h2: rate_cycles = 3'h1;
         default: rate_cycles = 3'h3;
      endcase
   endfunction

   // Sync compare mask, bit 7 always included
   function automatic logic [7:0] sync_mask(input logic [2:0] code);
      sync_mask = ~(8'h7f >> code);
   endfunction

   // Stored state
   logic [`FIB_NUM_EVENTS-1:0] flags; // Sticky event flags 0..6
   logic [`FIB_NUM_EVENTS-1:0] enables; // Interrupt enables 0..6
   logic [`FIB_NUM_EVENTS-1:0] events_q; // Previous event levels
   fib_pkg::fib_timing_t timing; // Write-only timing register
   logic [7:0] capture; // Shadow copy of last port read
   logic [7:0] rdata; // Registered read data
   logic [7:0] wdata_q; // Data held for a port write
   logic dir_write; // Current port access is a write
   logic [2:0] cnt; // Access cycle counter
   fib_pkg::fib_state_t state;
   fib_pkg::fib_state_t next_state;

   // Address decode
   wire sel_capture = (mcu_addr_i == `FIB_ADDR_CAPTURE);
   wire sel_port = (mcu_addr_i == `FIB_ADDR_PORT);
   wire sel_flags = (mcu_addr_i == `FIB_ADDR_FLAGS);
   wire sel_enables = (mcu_addr_i == `FIB_ADDR_ENABLES);
   wire sel_stack = (mcu_addr_i == `FIB_ADDR_STACK);
   wire sel_timing = (mcu_addr_i == `FIB_ADDR_TIMING);

   // Strobes
   wire idle = (state == fib_pkg::FIB_IDLE);
   wire in_acc = (state == fib_pkg::FIB_ACC);
   wire port_start = idle & sel_port & (mcu_rd_i | mcu_wr_i);
   wire flags_rd = mcu_rd_i & sel_flags;
   wire stack_rd = mcu_rd_i & sel_stack;
   wire acc_last = in_acc & (cnt == 3'h1);

   // Event edge detection on the packed source levels
   logic [`FIB_NUM_EVENTS-1:0] ev_now;
   logic [`FIB_NUM_EVENTS-1:0] ev_rise;
   logic [`FIB_NUM_EVENTS-1:0] flag_set;
   assign ev_now = events_i;
   assign ev_rise = ev_now & ~events_q;

   // Per-flag set terms; mark/sector only counts in hard-sector mode
   genvar gi;
   generate
      for (gi = 0; gi < `FIB_NUM_EVENTS; gi = gi + 1) begin : g_set
         if (gi == 1) begin : g_sector
            assign flag_set[gi] = ev_rise[gi] & hard_sector_i;
         end else begin : g_plain
            assign flag_set[gi] = ev_rise[gi];
         end
      end
   endgenerate

   // Read clears exactly the bits it returned; a new set wins
   logic [`FIB_NUM_EVENTS-1:0] next_flags;
   assign next_flags = (flags & ~(flags_rd ? flags : 7'h00)) | flag_set;

   // Summary of host-side pending interrupts
   wire host_irq_summary = |host_irq_bits_i;

   // Previous levels for rising-edge detection
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         events_q <= 7'h00;
      end else begin
         events_q <= ev_now;
      end
   end

   // Sticky flags, cleared by chip reset
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flags <= `FIB_FLAGS_RST;
      end else begin
         flags <= next_flags;
      end
   end

   // Enable register, low seven bits only
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         enables <= `FIB_ENABLES_RST;
      end else if (mcu_wr_i & sel_enables) begin
         enables <= mcu_wdata_i[`FIB_NUM_EVENTS-1:0];
      end
   end

   // Timing and sync register; rate comes up as one per clock
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         timing <= `FIB_TIMING_RST;
      end else if (mcu_wr_i & sel_timing) begin
         timing <= mcu_wdata_i;
      end
   end

   // Interrupt: low while any enabled flag is pending
   wire irq_pending = |(flags & enables);

   // Capture stack shared with the sequencer data path
   logic [7:0] stack_data;
   fib_read_stack u_stack (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .push_i(stack_push_i),
      .push_data_i(stack_data_i),
      .read_i(stack_rd),
      .read_data_o(stack_data)
   );

   // Buffer port access sequencer
   always_comb begin
      next_state = state;
      case (state)
         fib_pkg::FIB_IDLE: begin
            if (port_start) begin
               next_state = fib_pkg::FIB_ACC;
            end
         end
         fib_pkg::FIB_ACC: begin
            if (acc_last) begin
               next_state = fib_pkg::FIB_DONE;
            end
         end
         default: begin
            next_state = fib_pkg::FIB_IDLE;
         end
      endcase
   end

   // State, direction, write data and rate counter
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= fib_pkg::FIB_IDLE;
         dir_write <= 1'b0;
         wdata_q <= 8'h00;
         cnt <= 3'h0;
      end else begin
         state <= next_state;
         if (port_start) begin
            dir_write <= mcu_wr_i;
            wdata_q <= mcu_wdata_i;
            cnt <= rate_cycles(timing.rate);
         end else if (in_acc) begin
            cnt <= cnt - 3'h1;
         end
      end
   end

   // Shadow latch: bus sampled at the end of a port read
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         capture <= `FIB_CAPTURE_RST;
      end else if (formatter_reset_i) begin
         capture <= `FIB_CAPTURE_RST;
      end else if (acc_last & ~dir_write) begin
         capture <= buf_data_i;
      end
   end

   // Read data; a port read answers when its access completes
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata <= 8'h00;
      end else if (acc_last & ~dir_write) begin
         rdata <= buf_data_i;
      end else if (mcu_rd_i & ~sel_port) begin
         if (sel_flags) begin
            rdata <= {host_irq_summary, flags};
         end else if (sel_enables) begin
            rdata <= {1'b0, enables};
         end else if (sel_stack) begin
            rdata <= stack_data;
         end else if (sel_capture) begin
            rdata <= capture;
         end else begin
            rdata <= 8'h00;
         end
      end
   end

   // Gate inhibit follows the stopped level, one cycle late
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         gate_inhibit_o <= 1'b1;
      end else begin
         gate_inhibit_o <= events_i.seq_stopped;
      end
   end

   // Output enable terms; writes may hold it off to avoid bus fights
   wire port_oe = in_acc & (dir_write ? ~timing.wr_oe_dis : ~moe_suppress_i);
   wire ext_oe = ext_buf_oe_i & ~(ext_buf_write_i & timing.wr_oe_dis);

   // Address, data enable and write strobe active only while the port owns the bus; output enable also follows ext_oe
   assign buf_addr_o = in_acc ? (dir_write ? buffer_write_pointer_i : buffer_read_pointer_i) : 16'h0000;
   assign buf_data_o = wdata_q;
   assign buf_data_oe_n_o = ~(in_acc & dir_write);
   assign buffer_write_en_n_o = ~(in_acc & dir_write);
   assign buffer_out_enable_n_o = ~(port_oe | ext_oe);

   // One pointer step per completed access when enabled
   assign read_ptr_inc_o = acc_last & ~dir_write & auto_inc_i;
   assign write_ptr_inc_o = acc_last & dir_write & auto_inc_i;

   // Microcontroller side; ready drops until a port access ends
   assign mcu_rdata_o = rdata;
   assign mcu_ready_o = idle & ~port_start;

   // Status and control outputs
   assign fmt_int_n_o = ~irq_pending;
   assign revolution_mark_flag_o = flags[0];
   assign sector_pulse_flag_o = flags[1];
   assign sync_mask_o = sync_mask(timing.sync_cmp);
   assign access_rate_o = timing.rate;
   assign clk_disable_o = timing.clk_dis;

endmodule

//--- verification/fib_sram_model.sv
// Behavioural buffer SRAM on the buffer memory pins
`timescale 1ns/1ns
module fib_sram_model (
   input wire logic clk_i,
   input wire logic [15:0] addr_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [16]; // Low address bits only, enough for the port tests
   logic [7:0] last; // Last value the memory drove
   // Preload a known pattern
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 8'h30 + 8'(i);
      end
      last = 8'h00;
   end
   // Write on the clock while write enable is low, track last driven byte
   always @(posedge clk_i) begin
      if (!we_n_i) begin
         mem[addr_i[3:0]] <= wdata_i;
      end else if (!oe_n_i) begin
         last <= mem[addr_i[3:0]];
      end
   end
   // Released bus shows the inverse, so a stale copy never passes
   always_comb rdata_o = (!oe_n_i && we_n_i) ? mem[addr_i[3:0]] : ~last;
endmodule

//--- verification/fib_irq_buf_port_assertions.sv
// Port-level assertions for the formatter event and buffer port block
`timescale 1ns/1ns
module fib_irq_buf_port_chk (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire fib_pkg::fib_events_t events_i,
   input wire logic hard_sector_i,
   input wire logic auto_inc_i,
   input wire logic moe_suppress_i,
   input wire logic ext_buf_oe_i,
   input wire logic mcu_ready_o,
   input wire logic read_ptr_inc_o,
   input wire logic write_ptr_inc_o,
   input wire logic buffer_out_enable_n_o,
   input wire logic buf_data_oe_n_o,
   input wire logic fmt_int_n_o,
   input wire logic revolution_mark_flag_o,
   input wire logic sector_pulse_flag_o,
   input wire logic gate_inhibit_o,
   input wire logic [7:0] sync_mask_o
);
   // Interrupt released during reset
   rst_int_a: assert property (@(posedge sys_clk_i) sys_rst_i |-> fmt_int_n_o)
      else $error("interrupt low in reset");
   index_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(events_i.index) |-> ##[1:2] revolution_mark_flag_o) else $error("index flag missed");
   sector_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      hard_sector_i && $rose(events_i.mark_sector) |-> ##[1:2] sector_pulse_flag_o)
      else $error("sector flag missed");
   // Mask is always a run of ones from bit 7 down
   sync_shape_a: assert property (@(posedge sys_clk_i) sync_mask_o[7] && $onehot(~sync_mask_o + 8'h01))
      else $error("sync mask shape");
   gate_copy_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      events_i.seq_stopped |=> gate_inhibit_o) else $error("gates not dropped");
   // Port access ends within the slowest rate
   port_done_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $fell(mcu_ready_o) |-> ##[1:6] mcu_ready_o) else $error("port access hung");
   inc_cause_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (read_ptr_inc_o || write_ptr_inc_o) |-> auto_inc_i ##1 !(read_ptr_inc_o || write_ptr_inc_o))
      else $error("bad pointer step");
   suppress_oe_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      moe_suppress_i && !ext_buf_oe_i && buf_data_oe_n_o |-> buffer_out_enable_n_o)
      else $error("output enable not suppressed");
endmodule
bind fib_irq_buf_port fib_irq_buf_port_chk i_fib_irq_buf_port_chk (.sys_clk_i, .sys_rst_i, .events_i,
   .hard_sector_i, .auto_inc_i, .moe_suppress_i, .ext_buf_oe_i, .mcu_ready_o, .read_ptr_inc_o,
   .write_ptr_inc_o, .buffer_out_enable_n_o, .buf_data_oe_n_o, .fmt_int_n_o, .revolution_mark_flag_o,
   .sector_pulse_flag_o, .gate_inhibit_o, .sync_mask_o);

//--- verification/fib_irq_buf_port_tb_top.sv
// Self-checking bench for the formatter event and buffer port block
`timescale 1ns/1ns
module fib_irq_buf_port_tb_top;
   logic sys_clk_i, sys_rst_i, rd, wr, rdy, hs, push, frst, ainc, sup, rinc, winc, bdoe, oe_n, we_n;
   logic intn, revf, secf, gate, cdis, xoe, xwr;
   logic [7:0] addr, wd, rdata, sdata, bdi, bdo, smask, got;
   logic [4:0] host;
   logic [15:0] rp, wp, baddr, seen; // Seen holds the last address driven with a strobe low
   logic [1:0] rate;
   fib_pkg::fib_events_t ev; // Event source levels
   int err_count, comparisons, oe_cnt, inc_cnt;
   fib_irq_buf_port i_fib_irq_buf_port (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .mcu_addr_i(addr),
      .mcu_wdata_i(wd), .mcu_rd_i(rd), .mcu_wr_i(wr), .mcu_rdata_o(rdata), .mcu_ready_o(rdy), .events_i(ev),
      .hard_sector_i(hs), .host_irq_bits_i(host), .stack_push_i(push), .stack_data_i(sdata),
      .formatter_reset_i(frst), .auto_inc_i(ainc), .moe_suppress_i(sup), .buffer_read_pointer_i(rp),
      .buffer_write_pointer_i(wp), .read_ptr_inc_o(rinc), .write_ptr_inc_o(winc), .ext_buf_oe_i(xoe),
      .ext_buf_write_i(xwr), .buf_data_i(bdi), .buf_data_o(bdo), .buf_data_oe_n_o(bdoe), .buf_addr_o(baddr),
      .buffer_out_enable_n_o(oe_n), .buffer_write_en_n_o(we_n), .fmt_int_n_o(intn),
      .revolution_mark_flag_o(revf), .sector_pulse_flag_o(secf), .gate_inhibit_o(gate), .sync_mask_o(smask),
      .access_rate_o(rate), .clk_disable_o(cdis));
   fib_sram_model i_fib_sram_model (.clk_i(sys_clk_i), .addr_i(baddr), .oe_n_i(oe_n), .we_n_i(we_n),
      .wdata_i(bdo), .rdata_o(bdi));
   // Count output enable cycles and pointer steps
   always @(posedge sys_clk_i) begin
      oe_cnt = oe_cnt + int'(!oe_n);
      inc_cnt = inc_cnt + int'(rinc | winc);
      if (!oe_n || !we_n) begin
         seen = baddr;
      end
   end
   // Byte comparison, also used for flags widened to a byte
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // One register access; waits for ready with a bound, leaves read data in got
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge sys_clk_i);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge sys_clk_i);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      n = 0;
      while (rdy !== 1'b1 && n < 10) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      // A bound that runs out is a failure, not a silent pass
      if (rdy !== 1'b1) begin
         err_count++;
         $display("unexpected at %0t: ready never returned", $time);
      end
      got = rdata;
   endtask
   // Reset values and an unmapped read
   task automatic t_reset();
      chk(8'(intn), 8'h01);
      chk(smask, 8'h80);
      chk(8'(rate), 8'h02);
      acc(1'b0, 8'h7e, 8'h00);
      chk(got, 8'h00);
      acc(1'b0, 8'h7d, 8'h00);
      chk(got, 8'h00);
      acc(1'b0, 8'h00, 8'h00);
      chk(got, 8'h00);
   endtask
   // Each event source sets its flag, pulls the interrupt, clears on read
   task automatic t_events();
      acc(1'b1, 8'h7e, 8'h7f);
      for (int i = 0; i < 7; i++) begin
         @(posedge sys_clk_i);
         ev <= fib_pkg::fib_events_t'(7'h01 << i);
         repeat (3) @(posedge sys_clk_i);
         #1;
         chk(8'(intn), 8'h00);
         chk(8'({secf, revf}), (i < 2) ? 8'(1 << i) : 8'h00);
         chk(8'(gate), (i == 3) ? 8'h01 : 8'h00);
         @(posedge sys_clk_i);
         ev <= '0;
         acc(1'b0, 8'h7d, 8'h00);
         chk(got, 8'(1 << i));
         acc(1'b0, 8'h7d, 8'h00);
         chk(got, 8'h00);
         chk(8'(intn), 8'h01);
      end
      // Masked flags, soft sector mode, host summary bit
      acc(1'b1, 8'h7e, 8'h00);
      @(posedge sys_clk_i);
      hs <= 1'b0;
      ev <= fib_pkg::fib_events_t'(7'h03);
      host <= 5'h10;
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk(8'({intn, secf, revf}), 8'h05);
      acc(1'b0, 8'h7d, 8'h00);
      chk(got, 8'h81);
      acc(1'b0, 8'h7d, 8'h00);
      chk(got, 8'h80);
      @(posedge sys_clk_i);
      ev <= '0;
      host <= 5'h00;
   endtask
   // Ten pushes, then nine backward reads wrap round
   task automatic t_stack();
      for (int k = 0; k < 10; k++) begin
         @(posedge sys_clk_i);
         push <= 1'b1;
         sdata <= 8'h10 + 8'(k);
      end
      @(posedge sys_clk_i);
      push <= 1'b0;
      for (int k = 0; k < 9; k++) begin
         acc(1'b0, 8'h7f, 8'h00);
         chk(got, 8'h19 - 8'(k % 8));
      end
   endtask
   // Every sync code and rate code, clock stop kept clear
   task automatic t_timing();
      for (int c = 0; c < 8; c++) begin
         acc(1'b1, 8'h7f, {c[1:0], 3'b000, c[2:0]});
         chk(smask, 8'hff << (7 - c));
         chk(8'(rate), 8'(c[1:0]));
         chk(8'(cdis), 8'h00);
      end
   endtask
   // Port writes and reads at all rates, then suppress, write disable, latch reset
   task automatic t_port();
      @(posedge sys_clk_i);
      ainc <= 1'b1;
      #1;
      inc_cnt = 0;
      for (int r = 0; r < 4; r++) begin
         acc(1'b1, 8'h7f, {2'(r), 6'h00});
         acc(1'b1, 8'h70, 8'ha0 + 8'(r));
         chk(seen[15:8], 8'h02);
         oe_cnt = 0;
         acc(1'b0, 8'h70, 8'h00);
         chk(got, 8'ha0 + 8'(r));
         chk(seen[15:8], 8'h01);
         // Output enable cycles of one read equal the cycles per access of the rate code
         chk(8'(oe_cnt), (r == 0) ? 8'h04 : (r == 3) ? 8'h03 : 8'(3 - r));
         acc(1'b0, 8'h4d, 8'h00);
         chk(got, 8'ha0 + 8'(r));
      end
      chk(8'(inc_cnt), 8'h08);
      acc(1'b1, 8'h7f, 8'h90);
      @(posedge sys_clk_i);
      ainc <= 1'b0;
      sup <= 1'b1;
      #1;
      inc_cnt = 0;
      oe_cnt = 0;
      acc(1'b1, 8'h70, 8'h5a);
      chk(8'(oe_cnt), 8'h00);
      acc(1'b0, 8'h70, 8'h00);
      chk(8'(oe_cnt), 8'h00);
      chk(8'(inc_cnt), 8'h00);
      // Suppressed read samples the released bus, which shows the inverse of the last byte
      chk(got, 8'h5c);
      // Formatter or host traffic between port accesses: writes keep output enable off
      oe_cnt = 0;
      @(posedge sys_clk_i);
      xoe <= 1'b1;
      xwr <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      xwr <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      xoe <= 1'b0;
      #1;
      chk(8'(oe_cnt), 8'h02);
      @(posedge sys_clk_i);
      sup <= 1'b0;
      acc(1'b0, 8'h70, 8'h00);
      chk(got, 8'h5a);
      @(posedge sys_clk_i);
      frst <= 1'b1;
      @(posedge sys_clk_i);
      frst <= 1'b0;
      acc(1'b0, 8'h4d, 8'h00);
      chk(got, 8'h00);
   endtask
   // Verdict and end of run
   task automatic final_report();
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   // Main sequence
   initial begin
      {sys_rst_i, rd, wr, hs, push, frst, ainc, sup, xoe, xwr} = 10'h000;
      {addr, wd, sdata, host} = '0;
      ev = '0;
      // Same low address bits, different upper bytes, so a swapped pointer shows
      rp = 16'h0105;
      wp = 16'h0205;
      {err_count, comparisons, oe_cnt, inc_cnt} = '0;
      // Reset raised off the clock edge so every flop is cleared before the first edge
      #1;
      sys_rst_i <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      hs <= 1'b1;
      @(posedge sys_clk_i);
      #1;
      t_reset();
      t_events();
      t_stack();
      t_timing();
      t_port();
      final_report();
   end
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      err_count++;
      final_report();
   end
endmodule
